// *** logic/transmit_path_tail.sv ***
// transmit path tail: loop code, alignment, overwrite, buffer, encoder, TJA
// What this block does
// RQ1 - loop code pattern and length come from software per link
// RQ2 - loop code sent only while enabled and in T1/J1 mode
// RQ3 - framed: all channel bits carry loop code, F-bit kept
// RQ4 - unframed: channel bits and F-bit all carry loop code
// RQ5 - after loop code and alignment, before buffer and encoder, overwrite stream with ones or zeros on request
// RQ6 - zeros win when ones and zeros are both requested
// RQ7 - every toggle of alignment change deletes or repeats one bit
// RQ8 - master mode bypasses buffer; select picks recovered or master clock
// RQ9 - T1 slave at E1 backplane rate always uses buffer and master clock
// RQ10 - other slave modes, select one: master clock, buffer, slips
// RQ11 - other slave modes, select zero: bypass, backplane clock
// RQ12 - multiplexed mode behaves like the general slave modes
// RQ13 - B8ZS or AMI in T1/J1, HDB3 or AMI in E1, by line code bit
// RQ14 - each rising edge of violation insert puts one violation on line
// RQ15 - auto ones sends all ones while receive loss of signal holds
// RQ16 - attenuator is in or out of the path by its enable bit
// RQ17 - attenuator FIFO of 32, 64 or 128 bits, delay half the depth
// RQ18 - T1/J1 corner frequency 5 Hz or 1.26 Hz by bandwidth bit
// RQ19 - E1 corner frequency 6.77 Hz or 0.87 Hz by bandwidth bit
// RQ20 - FIFO slip sets status; interrupt output when status and enable set
// RQ21 - limit mode adjusts read rate near full or empty
// RQ22 - measure mode zero: field shows current pointer distance
// RQ23 - measure mode one: field keeps the larger distance
// RQ24 - slip status stays set until software clears it
// RQ25 - loop code repeats without gaps while sending stays enabled
module transmit_path_tail #(
  parameter int BUF_DEPTH = 16,
  parameter int ATTEN_MAX = 128
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // framer stream
  input wire logic tx_data,
  input wire logic tx_data_valid,
  input wire logic tx_fbit,
  output logic line_bit_tick,
  // receive path
  input wire logic rx_clock_tick,
  input wire logic rx_signal_loss,
  // line driver and interrupt
  output logic line_pos,
  output logic line_neg,
  output logic line_strobe,
  output logic irq
);
  if (BUF_DEPTH < 4 || BUF_DEPTH > 256
      || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_bad_buf_depth
    $error("BUF_DEPTH must be a power of two from 4 to 256");
  end
  if (ATTEN_MAX != 128) begin : g_bad_atten_max
    $error("ATTEN_MAX must be 128");
  end

  // registers
  logic [7:0] atten_cfg, tx_cfg0, maint1, maint2, int_en1, fgen_maint1;
  logic [7:0] timing_opt, loop_ctrl, loop_code_pattern;
  logic atten_slip_status;
  logic [6:0] jitter_measure_value;

  // apb decode
  wire [9:0] reg_idx = paddr[11:2];
  wire bus_setup = psel && !penable;
  wire bus_done = psel && penable && pready;
  wire bus_wr = bus_done && pwrite;
  wire bus_rd = bus_done && !pwrite;
  function automatic logic hit(input logic [9:0] idx, input logic [9:0] a);
    hit = (idx == a);
  endfunction
  wire known = hit(reg_idx, tx_tail_pkg::IDX_ATTEN_CFG)
    || hit(reg_idx, tx_tail_pkg::IDX_TX_CFG0)
    || hit(reg_idx, tx_tail_pkg::IDX_MAINT1)
    || hit(reg_idx, tx_tail_pkg::IDX_MAINT2)
    || hit(reg_idx, tx_tail_pkg::IDX_INT_EN1)
    || hit(reg_idx, tx_tail_pkg::IDX_MEASURE)
    || hit(reg_idx, tx_tail_pkg::IDX_INT_ST1)
    || hit(reg_idx, tx_tail_pkg::IDX_FGEN_MAINT1)
    || hit(reg_idx, tx_tail_pkg::IDX_TIMING)
    || hit(reg_idx, tx_tail_pkg::IDX_LOOP_CTRL)
    || hit(reg_idx, tx_tail_pkg::IDX_LOOP_CODE);
  wire [7:0] read_mux =
    hit(reg_idx, tx_tail_pkg::IDX_ATTEN_CFG) ? atten_cfg :
    hit(reg_idx, tx_tail_pkg::IDX_TX_CFG0) ? tx_cfg0 :
    hit(reg_idx, tx_tail_pkg::IDX_MAINT1) ? maint1 :
    hit(reg_idx, tx_tail_pkg::IDX_MAINT2) ? maint2 :
    hit(reg_idx, tx_tail_pkg::IDX_INT_EN1) ? int_en1 :
    hit(reg_idx, tx_tail_pkg::IDX_MEASURE) ? {1'b0, jitter_measure_value} :
    hit(reg_idx, tx_tail_pkg::IDX_INT_ST1) ? {7'h00, atten_slip_status} :
    hit(reg_idx, tx_tail_pkg::IDX_FGEN_MAINT1) ? fgen_maint1 :
    hit(reg_idx, tx_tail_pkg::IDX_TIMING) ? timing_opt :
    hit(reg_idx, tx_tail_pkg::IDX_LOOP_CTRL) ? loop_ctrl :
    hit(reg_idx, tx_tail_pkg::IDX_LOOP_CODE) ? loop_code_pattern : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= bus_setup;
      pslverr <= bus_setup && !known;
      if (bus_setup) prdata <= {24'h000000, read_mux};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      atten_cfg <= tx_tail_pkg::REG_RESET;
      tx_cfg0 <= tx_tail_pkg::REG_RESET;
      maint1 <= tx_tail_pkg::REG_RESET;
      maint2 <= tx_tail_pkg::REG_RESET;
      int_en1 <= tx_tail_pkg::REG_RESET;
      fgen_maint1 <= tx_tail_pkg::REG_RESET;
      timing_opt <= tx_tail_pkg::REG_RESET;
      loop_ctrl <= tx_tail_pkg::REG_RESET;
      loop_code_pattern <= tx_tail_pkg::REG_RESET;
    end else if (bus_wr) begin
      if (hit(reg_idx, tx_tail_pkg::IDX_ATTEN_CFG)) atten_cfg <= pwdata[7:0];
      if (hit(reg_idx, tx_tail_pkg::IDX_TX_CFG0)) tx_cfg0 <= pwdata[7:0];
      if (hit(reg_idx, tx_tail_pkg::IDX_MAINT1)) maint1 <= pwdata[7:0];
      if (hit(reg_idx, tx_tail_pkg::IDX_MAINT2)) maint2 <= pwdata[7:0];
      if (hit(reg_idx, tx_tail_pkg::IDX_INT_EN1)) int_en1 <= pwdata[7:0];
      if (hit(reg_idx, tx_tail_pkg::IDX_FGEN_MAINT1))
        fgen_maint1 <= pwdata[7:0];
      if (hit(reg_idx, tx_tail_pkg::IDX_TIMING)) timing_opt <= pwdata[7:0];
      if (hit(reg_idx, tx_tail_pkg::IDX_LOOP_CTRL)) loop_ctrl <= pwdata[7:0];
      if (hit(reg_idx, tx_tail_pkg::IDX_LOOP_CODE))
        loop_code_pattern <= pwdata[7:0];
    end
  end

  // control fields
  wire e1_mode = tx_cfg0[tx_tail_pkg::E1_MODE_BIT];
  wire ami_select = tx_cfg0[tx_tail_pkg::LINE_CODE_BIT];
  wire tss = timing_opt[tx_tail_pkg::TIMING_SEL_BIT];
  wire tx_master = timing_opt[tx_tail_pkg::TX_MASTER_BIT];
  wire bp_e1_rate = timing_opt[tx_tail_pkg::BP_E1_RATE_BIT];
  wire atten_enable = atten_cfg[tx_tail_pkg::ATTEN_ENABLE_BIT];
  wire [1:0] atten_fifo_depth = atten_cfg[tx_tail_pkg::ATTEN_DEPTH_LSB +: 2];
  wire atten_bw = atten_cfg[tx_tail_pkg::ATTEN_BW_BIT];
  wire atten_limit_enable = atten_cfg[tx_tail_pkg::ATTEN_LIMIT_BIT];
  wire measure_mode = atten_cfg[tx_tail_pkg::MEASURE_MODE_BIT];
  wire [1:0] loop_code_length = loop_ctrl[tx_tail_pkg::LOOP_LEN_LSB +: 2];
  wire loop_send = loop_ctrl[tx_tail_pkg::LOOP_SEND_BIT] && !e1_mode; // RQ2
  wire loop_unframed = loop_ctrl[tx_tail_pkg::LOOP_UNFRAMED_BIT];

  // receive loss of signal crosses in through two flops
  logic los_meta, los_sync;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      los_meta <= 1'b0;
      los_sync <= 1'b0;
    end else begin
      los_meta <= rx_signal_loss;
      los_sync <= los_meta;
    end
  end

  // master clock rate generator
  logic [31:0] master_phase;
  wire [32:0] master_sum = {1'b0, master_phase}
    + {1'b0, e1_mode ? tx_tail_pkg::INC_E1 : tx_tail_pkg::INC_T1};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) master_phase <= 32'h0000_0000;
    else master_phase <= master_sum[31:0];
  end
  wire master_tick = master_sum[32];

  // clock source and buffer use
  wire slave_t1_e1rate = !tx_master && bp_e1_rate && !e1_mode;
  wire buf_used = !tx_master && (slave_t1_e1rate || tss); // RQ9 RQ10 RQ11 RQ12
  wire line_tick = tx_master ? (tss ? master_tick : rx_clock_tick) : // RQ8
    (buf_used ? master_tick : tx_data_valid); // RQ9 RQ10 RQ11

  // loop code generator
  logic [2:0] loop_pos;
  wire [3:0] loop_len = tx_tail_pkg::LOOP_LEN_BASE + {2'b00, loop_code_length};
  wire loop_take = loop_send && (loop_unframed || !tx_fbit); // RQ3 RQ4
  wire loop_bit = loop_code_pattern[3'(loop_len - 4'h1) - loop_pos]; // RQ1
  wire stage1_bit = loop_take ? loop_bit : tx_data;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) loop_pos <= 3'h0;
    else if (!loop_send) loop_pos <= 3'h0;
    else if (tx_data_valid && loop_take)
      loop_pos <= ({1'b0, loop_pos} >= loop_len - 4'h1) ?
        3'h0 : loop_pos + 3'h1; // RQ25
  end

  // alignment change: output switches between current and previous bit
  logic prev_bit, align_sel, align_seen;
  wire align_chg = fgen_maint1[tx_tail_pkg::ALIGN_CHG_BIT];
  wire stage2_bit = align_sel ? prev_bit : stage1_bit;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_bit <= 1'b0;
      align_sel <= 1'b0;
      align_seen <= 1'b0;
    end else begin
      align_seen <= align_chg;
      if (align_chg != align_seen) align_sel <= !align_sel; // RQ7
      if (tx_data_valid) prev_bit <= stage1_bit;
    end
  end

  // all ones / all zeros overwrite
  wire zero_req = fgen_maint1[tx_tail_pkg::ALL_ZEROS_BIT];
  wire ones_req = fgen_maint1[tx_tail_pkg::ALL_ONES_BIT]
    || (maint1[tx_tail_pkg::AUTO_ONES_BIT] && los_sync); // RQ15
  wire stage3_bit = zero_req ? 1'b0 : (ones_req ? 1'b1 : stage2_bit); // RQ5 RQ6

  // transmit buffer, slips by recentring
  localparam int BW = $clog2(BUF_DEPTH);
  logic buf_mem [BUF_DEPTH];
  logic [BW:0] buf_wp, buf_rp;
  wire [BW:0] buf_fill = buf_wp - buf_rp;
  wire buf_rd = buf_used && line_tick;
  wire buf_wr = buf_used && tx_data_valid;
  wire buf_slip = (buf_wr && !buf_rd && buf_fill == (BW + 1)'(BUF_DEPTH))
    || (buf_rd && buf_fill == '0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_wp <= '0;
      buf_rp <= '0;
    end else if (!buf_used || buf_slip) begin
      buf_rp <= buf_wp - (BW + 1)'(BUF_DEPTH / 2); // RQ10
    end else begin
      if (buf_wr) buf_wp <= buf_wp + 1'b1;
      if (buf_rd) buf_rp <= buf_rp + 1'b1;
    end
  end
  always_ff @(posedge pclk) begin
    if (buf_wr) buf_mem[buf_wp[BW-1:0]] <= stage3_bit;
  end
  wire enc_step = buf_used ? line_tick : tx_data_valid;
  wire enc_in = buf_used ? buf_mem[buf_rp[BW-1:0]] : stage3_bit;

  // encoder with eight-symbol lookahead
  tx_tail_pkg::symbol_type sym [8];
  tx_tail_pkg::symbol_type nsym [8];
  logic pulse_parity, last_pol, viol_seen, viol_pending;
  wire four_zero = enc_in == 1'b0 && sym[0] == tx_tail_pkg::SYM_ZERO
    && sym[1] == tx_tail_pkg::SYM_ZERO && sym[2] == tx_tail_pkg::SYM_ZERO;
  wire eight_zero = four_zero && sym[3] == tx_tail_pkg::SYM_ZERO
    && sym[4] == tx_tail_pkg::SYM_ZERO && sym[5] == tx_tail_pkg::SYM_ZERO
    && sym[6] == tx_tail_pkg::SYM_ZERO;
  wire do_b8zs = !ami_select && !e1_mode && eight_zero; // RQ13
  wire do_hdb3 = !ami_select && e1_mode && four_zero; // RQ13
  always_comb begin
    nsym[0] = enc_in ? tx_tail_pkg::SYM_MARK : tx_tail_pkg::SYM_ZERO;
    for (int i = 1; i < 8; i++) nsym[i] = sym[i-1];
    if (do_b8zs) begin
      nsym[4] = tx_tail_pkg::SYM_VIOL;
      nsym[3] = tx_tail_pkg::SYM_BAL;
      nsym[1] = tx_tail_pkg::SYM_VIOL;
      nsym[0] = tx_tail_pkg::SYM_BAL;
    end
    if (do_hdb3) begin
      nsym[0] = tx_tail_pkg::SYM_VIOL;
      if (!pulse_parity) nsym[3] = tx_tail_pkg::SYM_BAL;
    end
  end
  wire viol_ins = maint2[tx_tail_pkg::VIOL_INS_BIT];
  wire out_pulse = sym[7] != tx_tail_pkg::SYM_ZERO;
  wire keep_pol = sym[7] == tx_tail_pkg::SYM_VIOL
    || (sym[7] == tx_tail_pkg::SYM_MARK && viol_pending);
  wire out_pol = keep_pol ? last_pol : !last_pol;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) sym[i] <= tx_tail_pkg::SYM_ZERO;
      pulse_parity <= 1'b0;
      last_pol <= 1'b0;
      viol_seen <= 1'b0;
      viol_pending <= 1'b0;
    end else begin
      viol_seen <= viol_ins;
      if (enc_step) begin
        sym <= nsym;
        if (do_hdb3) pulse_parity <= 1'b0;
        else if (enc_in) pulse_parity <= !pulse_parity;
        if (out_pulse) last_pol <= out_pol;
      end
      if (viol_ins && !viol_seen) viol_pending <= 1'b1; // RQ14
      else if (enc_step && sym[7] == tx_tail_pkg::SYM_MARK)
        viol_pending <= 1'b0; // RQ14
    end
  end
  wire enc_pos = out_pulse && out_pol;
  wire enc_neg = out_pulse && !out_pol;

  // jitter attenuator FIFO and DPLL
  logic [1:0] ja_mem [ATTEN_MAX];
  logic [7:0] ja_wp, ja_rp;
  logic [31:0] dpll_phase, dpll_inc;
  logic [1:0] depth_seen;
  wire [7:0] ja_depth = atten_fifo_depth == 2'h0 ? tx_tail_pkg::DEPTH_SMALL :
    atten_fifo_depth == 2'h1 ? tx_tail_pkg::DEPTH_MID :
    tx_tail_pkg::DEPTH_LARGE; // RQ17
  wire [7:0] ja_half = ja_depth >> 1;
  wire [7:0] ja_fill = ja_wp - ja_rp;
  wire [4:0] gain = e1_mode ?
    (atten_bw ? tx_tail_pkg::GAIN_E1_NARROW : tx_tail_pkg::GAIN_E1_WIDE) :
    (atten_bw ? tx_tail_pkg::GAIN_T1_NARROW :
      tx_tail_pkg::GAIN_T1_WIDE); // RQ18 RQ19
  wire [31:0] dpll_step = 32'h1 << gain;
  wire [32:0] dpll_sum = {1'b0, dpll_phase} + {1'b0, dpll_inc};
  wire near_full = ja_fill >= ja_depth - tx_tail_pkg::LIMIT_MARGIN;
  wire near_empty = ja_fill <= tx_tail_pkg::LIMIT_MARGIN;
  wire ja_rd = atten_enable && (atten_limit_enable ? // RQ21
    (near_full || (dpll_sum[32] && !near_empty)) : dpll_sum[32]);
  wire ja_wr = atten_enable && enc_step;
  wire ja_over = ja_wr && !ja_rd && ja_fill == ja_depth;
  wire ja_under = ja_rd && !ja_wr && ja_fill == 8'h00;
  wire ja_restart = !atten_enable || depth_seen != atten_fifo_depth;
  wire [6:0] cur_dist = ja_fill[6:0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ja_wp <= 8'h00;
      ja_rp <= 8'h00;
      depth_seen <= 2'h0;
      dpll_phase <= 32'h0000_0000;
      dpll_inc <= tx_tail_pkg::INC_T1;
    end else begin
      depth_seen <= atten_fifo_depth;
      dpll_phase <= dpll_sum[31:0];
      if (ja_restart) begin
        ja_rp <= ja_wp - ja_half; // RQ16 RQ17
        dpll_inc <= e1_mode ? tx_tail_pkg::INC_E1 : tx_tail_pkg::INC_T1;
      end else if (ja_over || ja_under) begin
        ja_rp <= ja_wp - ja_half;
        if (ja_wr) ja_wp <= ja_wp + 8'h01;
      end else begin
        if (ja_wr) ja_wp <= ja_wp + 8'h01;
        if (ja_rd) ja_rp <= ja_rp + 8'h01;
        if (ja_wr && ja_fill > ja_half) dpll_inc <= dpll_inc + dpll_step;
        if (ja_wr && ja_fill < ja_half) dpll_inc <= dpll_inc - dpll_step;
      end
    end
  end
  always_ff @(posedge pclk) begin
    if (ja_wr) ja_mem[ja_wp[6:0]] <= {enc_pos, enc_neg};
  end
  wire [1:0] ja_out = ja_mem[ja_rp[6:0]];

  // line outputs, status, measure and interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_pos <= 1'b0;
      line_neg <= 1'b0;
      line_strobe <= 1'b0;
      line_bit_tick <= 1'b0;
      atten_slip_status <= 1'b0;
      jitter_measure_value <= 7'h00;
      irq <= 1'b0;
    end else begin
      line_bit_tick <= line_tick;
      line_strobe <= atten_enable ? ja_rd : enc_step; // RQ16
      if (atten_enable ? ja_rd : enc_step) begin
        line_pos <= atten_enable ? ja_out[1] : enc_pos;
        line_neg <= atten_enable ? ja_out[0] : enc_neg;
      end
      if (ja_over || ja_under) atten_slip_status <= 1'b1; // RQ20 RQ24
      // clear only what the read returned, so a slip at setup is kept
      else if (bus_rd && hit(reg_idx, tx_tail_pkg::IDX_INT_ST1)
        && prdata[tx_tail_pkg::SLIP_BIT])
        atten_slip_status <= 1'b0; // RQ24
      if (!measure_mode) jitter_measure_value <= cur_dist; // RQ22
      else if (cur_dist > jitter_measure_value)
        jitter_measure_value <= cur_dist; // RQ23
      irq <= atten_slip_status && int_en1[tx_tail_pkg::SLIP_BIT]; // RQ20
    end
  end

  // checks
  AST_ZERO_WINS: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
    zero_req && ones_req |-> stage3_bit == 1'b0)
    else $error("all zeros did not win over all ones");
  AST_ONES_FILL: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
    ones_req && !zero_req |-> stage3_bit)
    else $error("all ones request not applied");
  AST_NO_LOOP_E1: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
    e1_mode |-> stage1_bit == tx_data)
    else $error("loop code active in E1 mode");
  AST_FBIT_KEPT: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
    loop_send && !loop_unframed && tx_fbit |-> stage1_bit == tx_data)
    else $error("F-bit overwritten in framed loop code mode");
  AST_VIOL_ARM: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
    viol_ins && !viol_seen |=> viol_pending)
    else $error("violation request not armed on rising edge");
  AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn) // RQ20
    atten_slip_status && int_en1[tx_tail_pkg::SLIP_BIT] |=> irq)
    else $error("interrupt missing for enabled slip status");
  AST_STICKY: assert property (@(posedge pclk) disable iff (!presetn) // RQ24
    atten_slip_status && !bus_rd |=> atten_slip_status)
    else $error("slip status dropped without a read");
  AST_PEAK: assert property (@(posedge pclk) disable iff (!presetn) // RQ23
    measure_mode && $past(measure_mode)
      |-> jitter_measure_value >= $past(jitter_measure_value))
    else $error("peak hold measure decreased");
  AST_MEASURE: assert property (@(posedge pclk) disable iff (!presetn) // RQ22
    !measure_mode |=> jitter_measure_value == $past(cur_dist))
    else $error("measure field not tracking distance");
  AST_MASTER_SRC: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
    tx_master && !tss && rx_clock_tick |=> line_bit_tick && !buf_used)
    else $error("master mode clock source or bypass wrong");
endmodule

// *** logic/tx_tail_pkg.sv ***
// constants of the transmit path tail: register map, fields, rates
package tx_tail_pkg;
  // register indices; the byte address is four times the index
  localparam logic [9:0] IDX_ATTEN_CFG = 10'h021;
  localparam logic [9:0] IDX_TX_CFG0 = 10'h022;
  localparam logic [9:0] IDX_MAINT1 = 10'h02c;
  localparam logic [9:0] IDX_MAINT2 = 10'h031;
  localparam logic [9:0] IDX_INT_EN1 = 10'h034;
  localparam logic [9:0] IDX_MEASURE = 10'h038;
  localparam logic [9:0] IDX_INT_ST1 = 10'h03b;
  localparam logic [9:0] IDX_FGEN_MAINT1 = 10'h06c;
  localparam logic [9:0] IDX_TIMING = 10'h070;
  localparam logic [9:0] IDX_LOOP_CTRL = 10'h074;
  localparam logic [9:0] IDX_LOOP_CODE = 10'h075;
  localparam logic [7:0] REG_RESET = 8'h00;
  // attenuator configuration fields
  localparam int ATTEN_ENABLE_BIT = 0;
  localparam int ATTEN_DEPTH_LSB = 1;
  localparam int ATTEN_BW_BIT = 3;
  localparam int ATTEN_LIMIT_BIT = 4;
  localparam int MEASURE_MODE_BIT = 5;
  // transmit configuration 0 fields
  localparam int LINE_CODE_BIT = 0;
  localparam int E1_MODE_BIT = 1;
  // single-bit fields in bit 0 of their registers
  localparam int AUTO_ONES_BIT = 0;
  localparam int VIOL_INS_BIT = 0;
  localparam int SLIP_BIT = 0;
  // frame generator maintenance fields
  localparam int ALL_ONES_BIT = 0;
  localparam int ALL_ZEROS_BIT = 1;
  localparam int ALIGN_CHG_BIT = 2;
  // timing option fields
  localparam int TIMING_SEL_BIT = 0;
  localparam int TX_MASTER_BIT = 1;
  localparam int BP_E1_RATE_BIT = 2;
  // loopback code control fields
  localparam int LOOP_LEN_LSB = 0;
  localparam int LOOP_SEND_BIT = 2;
  localparam int LOOP_UNFRAMED_BIT = 3;
  localparam logic [3:0] LOOP_LEN_BASE = 4'h5;
  // rates and corner frequencies (Hz, hundredths)
  localparam longint PCLK_HZ = 250000000;
  localparam longint T1_RATE_HZ = 1544000;
  localparam longint E1_RATE_HZ = 2048000;
  localparam int CF_T1_WIDE_CHZ = 500;
  localparam int CF_T1_NARROW_CHZ = 126;
  localparam int CF_E1_WIDE_CHZ = 677;
  localparam int CF_E1_NARROW_CHZ = 87;
  // DPLL frequency step per sample, larger step for the higher corner
  localparam logic [4:0] GAIN_T1_WIDE = 5'h0a;
  localparam logic [4:0] GAIN_T1_NARROW = 5'h08;
  localparam logic [4:0] GAIN_E1_WIDE = 5'h0b;
  localparam logic [4:0] GAIN_E1_NARROW = 5'h07;
  // phase increments of the 32-bit rate generators
  localparam logic [31:0] INC_T1 = 32'((T1_RATE_HZ << 32) / PCLK_HZ);
  localparam logic [31:0] INC_E1 = 32'((E1_RATE_HZ << 32) / PCLK_HZ);
  // attenuator depths in bits, and the limit margin
  localparam logic [7:0] DEPTH_SMALL = 8'h20;
  localparam logic [7:0] DEPTH_MID = 8'h40;
  localparam logic [7:0] DEPTH_LARGE = 8'h80;
  localparam logic [7:0] LIMIT_MARGIN = 8'h04;
  // line symbols
  typedef enum logic [1:0] {
    SYM_ZERO = 2'h0, SYM_MARK = 2'h1, SYM_VIOL = 2'h2, SYM_BAL = 2'h3
  } symbol_type;
endpackage

// *** sim/line_far_end.sv ***
// far-end line model: recovered clock, symbol, mark and violation tallies
module line_far_end (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // line symbols from the block
  input wire logic line_pos,
  input wire logic line_neg,
  input wire logic line_strobe,
  // recovered clock and tallies
  output logic rx_clock_tick,
  output int syms,
  output int marks,
  output int viols
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_pos;
  logic [2:0] div;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 3'h0;
      rx_clock_tick <= 1'b0;
      syms <= 0;
      marks <= 0;
      viols <= 0;
      last_pos <= 1'b0;
    end else begin
      div <= div + 3'h1;
      rx_clock_tick <= (div == 3'h7);
      if (line_strobe) begin
        syms <= syms + 1;
        // a mark with the polarity of the previous mark is a violation
        if (line_pos | line_neg) begin
          marks <= marks + 1;
          viols <= viols + ((line_pos == last_pos) ? 1 : 0);
          last_pos <= line_pos;
        end
      end
    end
  end
endmodule

// *** sim/tb_transmit_path_tail.sv ***
// testbench of the transmit path tail: apb setup, line symbol tallies
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %0t value mismatch", $time); end end
module tb_transmit_path_tail;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, tx_data = 0, tx_data_valid = 0, tx_fbit = 0;
  logic rx_clock_tick, rx_signal_loss = 0, line_pos, line_neg, line_strobe;
  logic line_bit_tick, irq, err;
  logic [7:0] rdat;
  logic [2:0] ph = 3'h0;
  int syms, marks, viols, m, v, fail_count = 0, n_tests = 0;
  always #2 pclk = ~pclk;
  // one backplane bit every eight clocks
  always @(posedge pclk) begin
    ph <= ph + 3'h1;
    tx_data_valid <= (ph == 3'h0);
  end
  transmit_path_tail i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_data, .tx_data_valid,
    .tx_fbit, .line_bit_tick, .rx_clock_tick, .rx_signal_loss, .line_pos,
    .line_neg, .line_strobe, .irq);
  line_far_end i_far (.pclk, .presetn, .line_pos, .line_neg, .line_strobe,
    .rx_clock_tick, .syms, .marks, .viols);
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic timeout;
    fail_count++;
    $display("CHECK FAILED %0t wait ran out", $time);
    end_sim;
  endtask
  task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
    int k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rdat = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (k >= 50) timeout();
  endtask
  // tally n symbols from now on
  task automatic tally(input int n);
    int s0 = syms, m0 = marks, v0 = viols, k = 0;
    while (syms - s0 < n && k < n * 40) begin
      @(posedge pclk);
      k++;
    end
    if (k >= n * 40) timeout();
    m = marks - m0;
    v = viols - v0;
  endtask
  // let the pipeline settle, then tally n symbols
  task automatic look(input int n);
    tally(24);
    tally(n);
  endtask
  task automatic t_regs;
    apb(0, tx_tail_pkg::IDX_TIMING, 8'h00);
    `CHK(rdat, tx_tail_pkg::REG_RESET)
    apb(1, tx_tail_pkg::IDX_LOOP_CODE, 8'ha5);
    apb(0, tx_tail_pkg::IDX_LOOP_CODE, 8'h00);
    `CHK(rdat, 8'ha5)
    apb(0, tx_tail_pkg::IDX_INT_ST1, 8'h00);
    `CHK(irq, 1'b0)
    apb(0, 10'h3ff, 8'h00);
    `CHK(err, 1'b1)
    $display("register test done");
  endtask
  task automatic t_code;
    logic [7:0] cfg [3] = '{8'h00, 8'h02, 8'h01};
    int em [3] = '{16, 16, 0};
    int ev [3] = '{8, 8, 0};
    for (int i = 0; i < 3; i++) begin
      apb(1, tx_tail_pkg::IDX_TX_CFG0, cfg[i]);
      look(32);
      `CHK(m, em[i])
      `CHK(v, ev[i])
    end
    $display("line code test done");
  endtask
  task automatic t_over;
    int em [3] = '{32, 0, 0};
    for (int i = 0; i < 3; i++) begin
      apb(1, tx_tail_pkg::IDX_FGEN_MAINT1, 8'(i + 1));
      look(32);
      `CHK(m, em[i])
    end
    apb(1, tx_tail_pkg::IDX_FGEN_MAINT1, 8'h00);
    apb(1, tx_tail_pkg::IDX_MAINT1, 8'h01);
    rx_signal_loss <= 1'b1;
    look(32);
    `CHK(m, 32)
    rx_signal_loss <= 1'b0;
    look(32);
    `CHK(m, 0)
    $display("overwrite test done");
  endtask
  task automatic t_viol;
    apb(1, tx_tail_pkg::IDX_FGEN_MAINT1, 8'h01);
    look(8);
    apb(1, tx_tail_pkg::IDX_MAINT2, 8'h01);
    tally(40);
    `CHK(v, 1)
    apb(1, tx_tail_pkg::IDX_MAINT2, 8'h00);
    tally(40);
    `CHK(v, 0)
    apb(1, tx_tail_pkg::IDX_FGEN_MAINT1, 8'h00);
    $display("violation test done");
  endtask
  task automatic t_loop;
    apb(1, tx_tail_pkg::IDX_LOOP_CODE, 8'haa);
    apb(1, tx_tail_pkg::IDX_LOOP_CTRL, 8'h07);
    look(32);
    `CHK(m, 16)
    apb(1, tx_tail_pkg::IDX_LOOP_CODE, 8'h03);
    apb(1, tx_tail_pkg::IDX_LOOP_CTRL, 8'h0d);
    look(30);
    `CHK(m, 10)
    apb(1, tx_tail_pkg::IDX_TX_CFG0, 8'h03);
    look(32);
    `CHK(m, 0)
    $display("loop code test done");
  endtask
  task automatic t_fbit;
    apb(1, tx_tail_pkg::IDX_TX_CFG0, 8'h01);
    apb(1, tx_tail_pkg::IDX_LOOP_CODE, 8'h00);
    tx_data <= 1'b1;
    tx_fbit <= 1'b1;
    apb(1, tx_tail_pkg::IDX_LOOP_CTRL, 8'h07);
    look(32);
    `CHK(m, 32)
    apb(1, tx_tail_pkg::IDX_LOOP_CTRL, 8'h0f);
    look(32);
    `CHK(m, 0)
    apb(1, tx_tail_pkg::IDX_LOOP_CTRL, 8'h00);
    tx_fbit <= 1'b0;
    $display("frame bit test done");
  endtask
  // count line bit ticks over 80 clocks
  task automatic ticks(output int k);
    k = 0;
    repeat (80) begin
      @(posedge pclk);
      k += line_bit_tick;
    end
  endtask
  task automatic t_time;
    int k;
    apb(1, tx_tail_pkg::IDX_TIMING, 8'h02);
    ticks(k);
    `CHK(k, 10)
    apb(1, tx_tail_pkg::IDX_TIMING, 8'h03);
    ticks(k);
    `CHK(k <= 1, 1'b1)
    apb(1, tx_tail_pkg::IDX_TIMING, 8'h00);
    $display("timing test done");
  endtask
  task automatic t_tja;
    apb(1, tx_tail_pkg::IDX_INT_EN1, 8'h01);
    apb(1, tx_tail_pkg::IDX_ATTEN_CFG, 8'h31);
    look(32);
    `CHK(m, 32)
    apb(0, tx_tail_pkg::IDX_MEASURE, 8'h00);
    `CHK(rdat, tx_tail_pkg::DEPTH_SMALL - tx_tail_pkg::LIMIT_MARGIN)
    apb(0, tx_tail_pkg::IDX_INT_ST1, 8'h00);
    `CHK(rdat, 8'h00)
    `CHK(irq, 1'b0)
    apb(1, tx_tail_pkg::IDX_ATTEN_CFG, 8'h01);
    repeat (200) @(posedge pclk);
    `CHK(irq, 1'b1)
    apb(0, tx_tail_pkg::IDX_INT_ST1, 8'h00);
    `CHK(rdat, 8'h01)
    apb(1, tx_tail_pkg::IDX_ATTEN_CFG, 8'h00);
    $display("attenuator test done");
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_code();
    t_over();
    t_viol();
    t_loop();
    t_fbit();
    t_time();
    t_tja();
    end_sim();
  end
endmodule
